// ### bench/dbs_chk.sv
// pin-level assertions for the burst-of-two sram port
`timescale 1ns/1ps
module dbs_chk
   import dbs_pkg::*;
(
   // clocks and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_out_clk,
   // command
   input wire logic i_cmd_valid_n,
   input wire logic i_dir_sel,
   // observed outputs
   input wire logic o_dq_oe,
   input wire logic o_echo_strobe_pos,
   input wire logic o_echo_strobe_neg,
   input wire logic o_impedance_update,
   input wire logic o_single_clock
);
   logic [5:0] since_rd;
   // saturates so a stale read never licenses a late burst
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         since_rd <= 6'h3f;
      else if (!i_cmd_valid_n && i_dir_sel)
         since_rd <= 6'h0;
      else if (since_rd != 6'h3f)
         since_rd <= since_rd + 6'h1;
   end
   property p_pair;
      @(posedge i_clk) disable iff (!i_reset_n) o_echo_strobe_neg != o_echo_strobe_pos;
   endproperty
   a_pair: assert property (p_pair) else $error("strobes not complementary");
   property p_tog_out;
      @(posedge i_out_clk) disable iff (!i_reset_n) !o_single_clock &&
         $changed(o_echo_strobe_pos) |=> $changed(o_echo_strobe_pos) || o_single_clock;
   endproperty
   a_tog_out: assert property (p_tog_out) else $error("strobe stopped");
   property p_tog_k;
      // the strobe source swaps a few link edges after the strap settles
      @(posedge i_clk) disable iff (!i_reset_n) o_single_clock && $past(o_single_clock, 8) &&
         $changed(o_echo_strobe_pos) |=> $changed(o_echo_strobe_pos);
   endproperty
   a_tog_k: assert property (p_tog_k) else $error("single strobe stopped");
   property p_imp;
      @(posedge i_clk) disable iff (!i_reset_n)
         $rose(o_impedance_update) |=> !o_impedance_update [*8];
   endproperty
   a_imp: assert property (p_imp) else $error("retune pulse too long");
   property p_burst;
      @(posedge i_out_clk) disable iff (!i_reset_n) $rose(o_dq_oe) |-> o_dq_oe [*3] ##1 !o_dq_oe;
   endproperty
   a_burst: assert property (p_burst) else $error("burst drive length wrong");
   property p_answer;
      @(posedge i_clk) disable iff (!i_reset_n) !i_cmd_valid_n && i_dir_sel |-> ##[2:40] o_dq_oe;
   endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   property p_quiet;
      @(posedge i_clk) disable iff (!i_reset_n) $rose(o_dq_oe) |-> since_rd < 6'h28;
   endproperty
   a_quiet: assert property (p_quiet) else $error("drive without read");
   property p_strap;
      @(posedge i_clk) disable iff (!i_reset_n) !$fell(o_single_clock);
   endproperty
   a_strap: assert property (p_strap) else $error("strap changed");
   c_read: cover property (@(posedge i_out_clk) $rose(o_dq_oe));
   c_imp: cover property (@(posedge i_clk) $rose(o_impedance_update));
   c_single: cover property (@(posedge i_clk) o_single_clock);
endmodule : dbs_chk
bind dbs_sram_port dbs_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_out_clk(i_out_clk),
   .i_cmd_valid_n(i_cmd_valid_n), .i_dir_sel(i_dir_sel), .o_dq_oe(o_dq_oe),
   .o_echo_strobe_pos(o_echo_strobe_pos), .o_echo_strobe_neg(o_echo_strobe_neg),
   .o_impedance_update(o_impedance_update), .o_single_clock(o_single_clock));

// ### bench/dbs_ctrl_model.sv
// memory controller model: issues bursts and catches read words
`timescale 1ns/1ps
module dbs_ctrl_model
   import dbs_pkg::*;
(
   // clocks
   input wire logic i_clk,
   input wire logic i_out_clk,
   // read side
   input wire logic [dbs_pkg::DATA_W-1:0] i_dq,
   input wire logic i_dq_oe,
   // command and write side
   output logic o_cmd_valid_n = 1'b1,
   output logic o_dir_sel = 1'b0,
   output logic [dbs_pkg::ADDR_W-1:0] o_addr = 4'h0,
   output logic [dbs_pkg::DATA_W-1:0] o_dq_rise = 36'h0,
   output logic [dbs_pkg::DATA_W-1:0] o_dq_fall = 36'h0,
   output logic [dbs_pkg::LANES-1:0] o_mask_rise = 4'hf,
   output logic [dbs_pkg::LANES-1:0] o_mask_fall = 4'hf
);
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                     input logic [LANES-1:0] m0, m1);
      @(negedge i_clk);
      o_cmd_valid_n = 1'b0;
      o_dir_sel = 1'b0;
      o_addr = a;
      @(negedge i_clk);
      o_cmd_valid_n = 1'b1;
      o_dq_rise = d0;
      o_dq_fall = d1;
      o_mask_rise = m0;
      o_mask_fall = m1;
      @(negedge i_clk);
      // released data and address lines carry junk so stale values cannot pass
      o_dq_rise = ~d0;
      o_dq_fall = ~d1;
      o_addr = ~a;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] w0, w1,
                     output logic ok);
      int n;
      @(negedge i_clk);
      o_cmd_valid_n = 1'b0;
      o_dir_sel = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_cmd_valid_n = 1'b1;
      o_addr = ~a;
      for (n = 0; n < 60 && i_dq_oe !== 1'b1; n++)
         @(negedge i_out_clk);
      ok = i_dq_oe;
      w0 = i_dq;
      @(negedge i_out_clk);
      w1 = i_dq;
      // let the drain finish: idle before any following write
      repeat (3) @(negedge i_out_clk);
   endtask : rd
endmodule : dbs_ctrl_model

// ### bench/dbs_sram_port_tb_top.sv
// self-checking bench for the burst-of-two sram port
`timescale 1ns/1ps
module dbs_sram_port_tb_top;
   import dbs_pkg::*;
   logic clk = 1'b0;
   logic clk_run = 1'b1;
   logic out_clk = 1'b0;
   logic rst_n = 1'b0;
   logic byp_n = 1'b1;
   logic strap = 1'b0;
   logic cmd_n, dir, oe, sp, sn, upd, lock, single;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_r, dq_f, dq, w0, w1;
   logic [LANES-1:0] m_r, m_f;
   logic ok;
   int fails = 0;
   int checks_done = 0;
   always #2.5 clk = clk_run ? ~clk : clk;
   always #6 out_clk = ~out_clk;
   dbs_ctrl_model u_ctl (.i_clk(clk), .i_out_clk(out_clk), .i_dq(dq), .i_dq_oe(oe),
      .o_cmd_valid_n(cmd_n), .o_dir_sel(dir), .o_addr(addr), .o_dq_rise(dq_r),
      .o_dq_fall(dq_f), .o_mask_rise(m_r), .o_mask_fall(m_f));
   dbs_sram_port dut (.i_clk(clk), .i_reset_n(rst_n), .i_out_clk(out_clk),
      .i_pll_bypass_n(byp_n), .i_out_timing_pos(strap), .i_out_timing_neg(strap),
      .i_impedance_ref(1'b0), .i_cmd_valid_n(cmd_n), .i_dir_sel(dir), .i_addr(addr),
      .i_dq_rise(dq_r), .i_lane_write_mask_n_rise(m_r), .i_dq_fall(dq_f),
      .i_lane_write_mask_n_fall(m_f), .o_dq(dq), .o_dq_oe(oe), .o_echo_strobe_pos(sp),
      .o_echo_strobe_neg(sn), .o_impedance_update(upd), .o_pll_locked(lock),
      .o_single_clock(single));
   task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic do_reset(input logic b, input logic s);
      @(negedge clk);
      rst_n = 1'b0;
      byp_n = b;
      strap = s;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask : do_reset
   task automatic t_burst;
      check("idle oe", oe, 1'b0);
      u_ctl.wr(4'h4, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
      u_ctl.wr(4'h7, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
      u_ctl.rd(4'h4, w0, w1, ok);
      check("rd4 w0", w0, 36'h123456789);
      check("rd4 w1", w1, 36'hfedcba987);
      u_ctl.rd(4'h6, w0, w1, ok);
      check("rd6 w0", w0, 36'h222222222);
      check("rd6 w1", w1, 36'h111111111);
      u_ctl.wr(4'h4, 36'hfffffffff, 36'h0, 4'hd, 4'hf);
      u_ctl.rd(4'h4, w0, w1, ok);
      check("lane w0", w0, 36'h12347ff89);
      check("lane w1", w1, 36'hfedcba987);
      check("read oe", ok, 1'b1);
      $display("test burst done");
   endtask : t_burst
   task automatic t_standby;
      // park the input clock low past the pll reset time, then resume and use the array
      @(negedge clk);
      clk_run = 1'b0;
      #41;
      clk_run = 1'b1;
      repeat (4) @(negedge clk);
      u_ctl.wr(4'h9, 36'h0c3c3c3c3, 36'h03c3c3c3c, 4'h0, 4'h0);
      u_ctl.rd(4'h8, w0, w1, ok);
      check("standby w0", w0, 36'h03c3c3c3c);
      check("standby w1", w1, 36'h0c3c3c3c3);
      $display("test standby done");
   endtask : t_standby
   task automatic t_timers;
      int n;
      for (n = 0; n < 1100 && upd !== 1'b1; n++)
         @(negedge clk);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (upd !== 1'b1 && n < 1100);
      check("retune gap", 36'(n), 36'(IMP_PERIOD));
      check("lock early", lock, 1'b0);
      // lock lands a few edges after the count because the bypass pin is synchronised first
      repeat (PLL_LOCK_CYC - 2 * IMP_PERIOD - 8) @(negedge clk);
      check("lock not yet", lock, 1'b0);
      repeat (16) @(negedge clk);
      check("lock late", lock, 1'b1);
      $display("test timers done");
   endtask : t_timers
   task automatic t_single;
      logic s0;
      do_reset(1'b0, 1'b1);
      check("strap", single, 1'b1);
      check("legacy lock", lock, 1'b1);
      // the echo source swaps only after the strap crosses into the link domain
      repeat (8) @(negedge clk);
      s0 = sp;
      @(negedge clk);
      check("k strobe", sp, !s0);
      u_ctl.wr(4'h2, 36'h0a5a5a5a5, 36'h05a5a5a5a, 4'h0, 4'h0);
      u_ctl.rd(4'h2, w0, w1, ok);
      check("legacy w0", w0, 36'h0a5a5a5a5);
      check("legacy w1", w1, 36'h05a5a5a5a);
      $display("test single done");
   endtask : t_single
   initial begin
      #100000;
      fails++;
      conclude();
   end
   initial begin
      do_reset(1'b1, 1'b0);
      t_burst();
      t_standby();
      t_timers();
      t_single();
      conclude();
   end
endmodule : dbs_sram_port_tb_top

// ### design/dbs_sram_port.sv
// burst-of-two double-rate sram port: command, array, posted write and read launch
`timescale 1ns/1ps
module dbs_sram_port
   import dbs_pkg::*;
(
   // core clock (input timing) and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // output timing clock, clocks the launch logic
   input wire logic i_out_clk,
   // static pins
   input wire logic i_pll_bypass_n,
   input wire logic i_out_timing_pos,
   input wire logic i_out_timing_neg,
   input wire logic i_impedance_ref,
   // command
   input wire logic i_cmd_valid_n,
   input wire logic i_dir_sel,
   input wire logic [dbs_pkg::ADDR_W-1:0] i_addr,
   // write data, rise and fall phase
   input wire logic [dbs_pkg::DATA_W-1:0] i_dq_rise,
   input wire logic [dbs_pkg::LANES-1:0] i_lane_write_mask_n_rise,
   input wire logic [dbs_pkg::DATA_W-1:0] i_dq_fall,
   input wire logic [dbs_pkg::LANES-1:0] i_lane_write_mask_n_fall,
   // read data and strobes
   output logic [dbs_pkg::DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   output logic o_echo_strobe_pos,
   output logic o_echo_strobe_neg,
   // status
   output logic o_impedance_update,
   output logic o_pll_locked,
   output logic o_single_clock
);
   import dbs_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_word,
                                                     input logic [DATA_W-1:0] new_word,
                                                     input logic [LANES-1:0] mask_n);
      logic [DATA_W-1:0] res;
      res = old_word;
      for (int i = 0; i < LANES; i++) begin
         if (!mask_n[i]) begin
            res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction : merge_lanes

   // ----------------------------------------
   // pin synchronisers and strap
   // ----------------------------------------
   logic [2:0] byp_sync;
   logic [2:0] cpos_sync;
   logic [2:0] cneg_sync;
   logic bypass_n;
   logic [1:0] strap_cnt;
   logic strap_done;
   logic single_clk;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         byp_sync <= 3'h0;
         cpos_sync <= 3'h0;
         cneg_sync <= 3'h0;
      end else begin
         byp_sync <= {byp_sync[1:0], i_pll_bypass_n};
         cpos_sync <= {cpos_sync[1:0], i_out_timing_pos};
         cneg_sync <= {cneg_sync[1:0], i_out_timing_neg};
      end
   end

   // reset as pll-on, but the cleared synchroniser reads bypass first, so the lock flag pulses high for three cycles before the pin is seen
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bypass_n <= 1'b1;
      end else if (byp_sync[2] == byp_sync[1]) begin
         bypass_n <= byp_sync[2];
      end
   end

   // strap is taken once after release and then frozen
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         single_clk <= 1'b0;
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == STRAP_TAKE) begin
            strap_done <= 1'b1;
            single_clk <= cpos_sync[2] & cpos_sync[1] & cneg_sync[2] & cneg_sync[1];
         end
      end
   end
   assign o_single_clock = single_clk;

   // ----------------------------------------
   // impedance cadence and pll lock
   // ----------------------------------------
   logic [10:0] imp_cnt;
   logic [12:0] lock_cnt;

   // the reference pin is analog; only the update cadence lives here
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         imp_cnt <= 11'h0;
         o_impedance_update <= 1'b0;
      end else begin
         o_impedance_update <= (imp_cnt == IMP_LAST);
         imp_cnt <= (imp_cnt == IMP_LAST) ? 11'h0 : imp_cnt + 11'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lock_cnt <= 13'h0;
         o_pll_locked <= 1'b0;
      end else if (!bypass_n) begin
         lock_cnt <= 13'h0;
         o_pll_locked <= 1'b1;
      end else if (lock_cnt == PLL_LOCK_LAST) begin
         o_pll_locked <= 1'b1;
      end else begin
         lock_cnt <= lock_cnt + 13'h1;
         o_pll_locked <= 1'b0;
      end
   end

   // ----------------------------------------
   // command stage, array and posted write
   // ----------------------------------------
   logic wr_pend;
   logic rd_pend;
   logic [ADDR_W-1:0] cmd_addr;
   logic [DATA_W-1:0] mem [DEPTH];
   logic post_valid;
   logic [ADDR_W-1:0] post_addr;
   logic [DATA_W-1:0] post_data;
   logic [ADDR_W-1:0] burst_addr;
   logic [DATA_W-1:0] rd_word0;
   logic [DATA_W-1:0] rd_word1;
   logic rd_tog;

   assign burst_addr = {cmd_addr[ADDR_W-1:1], ~cmd_addr[0]};

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         cmd_addr <= '0;
      end else begin
         wr_pend <= !i_cmd_valid_n && !i_dir_sel;
         rd_pend <= !i_cmd_valid_n && i_dir_sel;
         cmd_addr <= i_addr;
      end
   end

   // first word goes straight in; second word waits in the posted register
   // so a following read never collides with the array write
   always_ff @(posedge i_clk) begin
      if (wr_pend) begin
         // a posted word at this address is newer than the array copy
         mem[cmd_addr] <= merge_lanes((post_valid && post_addr == cmd_addr) ? post_data
                                      : mem[cmd_addr],
                                      i_dq_rise, i_lane_write_mask_n_rise);
         if (post_valid && post_addr != cmd_addr) begin
            mem[post_addr] <= post_data;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         post_valid <= 1'b0;
         post_addr <= '0;
         post_data <= DATA_RESET;
      end else if (wr_pend) begin
         post_valid <= 1'b1;
         post_addr <= burst_addr;
         post_data <= merge_lanes((post_valid && post_addr == burst_addr) ? post_data
                                  : mem[burst_addr], i_dq_fall, i_lane_write_mask_n_fall);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_word0 <= DATA_RESET;
         rd_word1 <= DATA_RESET;
         rd_tog <= 1'b0;
      end else if (rd_pend) begin
         rd_word0 <= (post_valid && post_addr == cmd_addr) ? post_data : mem[cmd_addr];
         rd_word1 <= (post_valid && post_addr == burst_addr) ? post_data : mem[burst_addr];
         rd_tog <= ~rd_tog;
      end
   end

   // core-domain phase used for echo strobes in single clock mode
   logic core_ph;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         core_ph <= 1'b0;
      end else begin
         core_ph <= ~core_ph;
      end
   end

   // ----------------------------------------
   // output timing domain
   // ----------------------------------------
   // read words stay still until the next read, so the toggle alone crosses;
   // reads closer than the crossing time overrun, a known limitation
   logic [2:0] tog_sync;
   logic [1:0] mode_sync_a;
   logic [1:0] mode_sync_b;
   logic rd_event;
   logic [1:0] wait_cnt;
   logic link_ph;
   dbs_out_t out_state;
   dbs_out_t next_out_state;

   always_ff @(posedge i_out_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tog_sync <= 3'h0;
         mode_sync_a <= 2'h3;
         mode_sync_b <= 2'h0;
         link_ph <= 1'b0;
      end else begin
         tog_sync <= {tog_sync[1:0], rd_tog};
         mode_sync_a <= {mode_sync_a[0], bypass_n};
         mode_sync_b <= {mode_sync_b[0], single_clk};
         link_ph <= ~link_ph;
      end
   end
   assign rd_event = tog_sync[2] ^ tog_sync[1];

   assign o_echo_strobe_pos = mode_sync_b[1] ? core_ph : link_ph;
   assign o_echo_strobe_neg = ~o_echo_strobe_pos;

   always_comb begin
      next_out_state = out_state;
      case (out_state)
         DBS_IDLE: if (rd_event) next_out_state = DBS_WAIT;
         DBS_WAIT: if (wait_cnt == 2'h1) next_out_state = DBS_WORD0;
         DBS_WORD0: next_out_state = DBS_WORD1;
         DBS_WORD1: next_out_state = rd_event ? DBS_WAIT : DBS_DRAIN;
         DBS_DRAIN: next_out_state = rd_event ? DBS_WAIT : DBS_IDLE;
         default: next_out_state = DBS_IDLE;
      endcase
   end

   always_ff @(posedge i_out_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_state <= DBS_IDLE;
         wait_cnt <= 2'h0;
      end else begin
         out_state <= next_out_state;
         if (rd_event) begin
            wait_cnt <= mode_sync_a[1] ? LAT_PLL : LAT_LEGACY;
         end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
         end
      end
   end

   always_ff @(posedge i_out_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_dq <= DATA_RESET;
         o_dq_oe <= 1'b0;
      end else begin
         case (next_out_state)
            DBS_WORD0: begin
               o_dq <= rd_word0;
               o_dq_oe <= 1'b1;
            end
            DBS_WORD1: begin
               o_dq <= rd_word1;
               o_dq_oe <= 1'b1;
            end
            DBS_DRAIN: o_dq_oe <= 1'b1;
            default: o_dq_oe <= 1'b0;
         endcase
      end
   end
endmodule : dbs_sram_port

// ### include/dbs_pkg.sv
// constants and types shared by the burst-of-two sram port
package dbs_pkg;
   localparam int DATA_W = 36;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int ADDR_W = 4;
   localparam int DEPTH = 16;
   // impedance re-tune cadence in clock cycles
   localparam int IMP_PERIOD = 1024;
   localparam logic [10:0] IMP_LAST = 11'(IMP_PERIOD - 1);
   // pll lock time after stable clock
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PLL_LOCK_US = 20;
   localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000000) / CLK_PERIOD_PS;
   localparam logic [12:0] PLL_LOCK_LAST = 13'(PLL_LOCK_CYC - 1);
   // core cycles after reset before the strap is taken (equal to the sync depth)
   localparam logic [1:0] STRAP_TAKE = 2'h3;
   // link-side wait edges before the first word, pll on and legacy mode
   localparam logic [1:0] LAT_PLL = 2'h2;
   localparam logic [1:0] LAT_LEGACY = 2'h1;
   localparam logic [DATA_W-1:0] DATA_RESET = 36'h0;
   typedef enum logic [2:0] {DBS_IDLE, DBS_WAIT, DBS_WORD0, DBS_WORD1, DBS_DRAIN} dbs_out_t;
endpackage : dbs_pkg
